// file: shared/eeprom_read_consts.svh
`ifndef EEPROM_READ_CONSTS_SVH
`define EEPROM_READ_CONSTS_SVH
// reset contents of array bytes and protection register
`define MEM_RESET      8'hFF
`define PROT_RESET     8'h00
// protection register field positions
`define PROT_ACT_BIT   3
`define PROT_SIZE_HI   2
`define PROT_SIZE_LO   1
`define PROT_LOCK_BIT  0
// upper address bit that selects the protection register
`define REG_SEL_BIT    7
// direction bit value of a read select
`define DIR_READ       1'h1
// bit index of the last bit of a byte
`define LAST_BIT       4'h7
`endif

// file: shared/eeprom_read_pkg.sv
`default_nettype none
package eeprom_read_pkg;
   // serial link protocol states
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_RX     = 3'b001,
      ST_RX_ACK = 3'b010,
      ST_TX     = 3'b011,
      ST_TX_ACK = 3'b100
   } link_state_e;
   // meaning of the byte being received
   typedef enum logic [1:0] {
      K_SEL = 2'b00,
      K_HI  = 2'b01,
      K_LO  = 2'b10
   } rx_kind_e;
endpackage
`default_nettype wire

// file: rtl/eeprom_serial_read_engine.sv
// Contract
// [RL1] reads ignore block protection setting
// [RL2] completed read advances counter by one
// [RL3] no master ack ends read, standby
// [RL4] random read: dummy write, restart, read
// [RL5] master nacks single byte, then stops
// [RL6] current read returns counter byte, increments
// [RL7] acked bytes continue from next address
// [RL8] master ends stream with nack, stop
// [RL9] counter wraps to zero after top
// [RL10] address msb set selects protection register
// [RL11] register read: upper nibble zero
// [RL12] register reads repeat same value
// [RL13] no register reads during programming
// [RL14] array resets FFh, register 00h
// [RL15] select byte msb first, acked if matching
// [RL16] two address bytes load the counter
// [RL17] register fields: enable, size, lock
// [RL18] busy programming ignores all requests
// [RL19] after nack stay released until start
// [RL20] abort before data keeps counter
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_read_consts.svh"
module eeprom_serial_read_engine #(
   parameter int         ADDR_W      = 12,
   parameter logic [6:0] SELECT_CODE = 7'h33 // arbitrary value
) (
   input  wire logic              I_CLK,
   input  wire logic              I_RESETN,
   input  wire logic              I_LINK_CLK,
   input  wire logic              I_SCL,
   input  wire logic              I_SDA_I,
   output logic                   O_SDA_O,
   output logic                   O_SDA_OE,
   input  wire logic              I_PROG_BUSY,
   input  wire logic              I_MEM_WR,
   input  wire logic [ADDR_W-1:0] I_MEM_WADDR,
   input  wire logic [7:0]        I_MEM_WDATA,
   input  wire logic              I_PROT_WR,
   input  wire logic [7:0]        I_PROT_WDATA,
   output logic                   O_PROT_ACTIVE,
   output logic [1:0]             O_PROT_SIZE,
   output logic                   O_PROT_LOCK
);
   localparam int DEPTH = 2 ** ADDR_W;

   // link domain signals
   logic [2:0]                   rst_sync;
   logic                         link_rst_n;
   logic [2:0]                   scl_q;
   logic [2:0]                   sda_q;
   logic [2:0]                   busy_q;
   logic [2:0]                   ack_q;
   logic                         scl_lvl_reg;
   logic                         sda_lvl_reg;
   logic                         scl_old_reg;
   logic                         sda_old_reg;
   logic                         busy_lvl_reg;
   logic                         ack_seen_reg;
   logic                         scl_rise;
   logic                         scl_fall;
   logic                         start_det;
   logic                         stop_det;
   eeprom_read_pkg::link_state_e state_reg;
   eeprom_read_pkg::rx_kind_e    kind_reg;
   logic [3:0]                   bit_reg;
   logic [7:0]                   shift_reg;
   logic [7:0]                   rx_byte;
   logic [7:0]                   addr_hi_reg;
   logic [ADDR_W-1:0]            cnt_reg;
   logic                         reg_sel_reg;
   logic                         oe_reg;
   logic                         rd_reg;
   logic                         mack_reg;
   logic [7:0]                   tx_reg;
   logic                         req_tog_reg;
   logic [ADDR_W-1:0]            req_addr_reg;
   logic                         req_sel_reg;
   logic [7:0]                   link_data_reg;

   // core domain signals
   logic [2:0]                   req_q;
   logic                         req_seen_reg;
   logic                         req_new;
   logic                         ack_tog_reg;
   logic [7:0]                   rdata_reg;
   logic [7:0]                   prot_reg;
   logic [7:0]                   mem_reg [DEPTH];

   // link reset derived from the core reset
   always_ff @(posedge I_LINK_CLK) begin
      rst_sync <= {rst_sync[1:0], I_RESETN};
   end
   assign link_rst_n = rst_sync[2] & rst_sync[1];

   // three-stage synchronisers for pins and cross-domain levels
   always_ff @(posedge I_LINK_CLK) begin
      if (!link_rst_n) begin
         scl_q  <= 3'h7;
         sda_q  <= 3'h7;
         busy_q <= 3'h0;
         ack_q  <= 3'h0;
      end else begin
         scl_q  <= {scl_q[1:0], I_SCL};
         sda_q  <= {sda_q[1:0], I_SDA_I};
         busy_q <= {busy_q[1:0], I_PROG_BUSY};
         ack_q  <= {ack_q[1:0], ack_tog_reg};
      end
   end

   // filtered levels, taken when the last two stages agree
   always_ff @(posedge I_LINK_CLK) begin
      if (!link_rst_n) begin
         scl_lvl_reg  <= 1'h1;
         sda_lvl_reg  <= 1'h1;
         scl_old_reg  <= 1'h1;
         sda_old_reg  <= 1'h1;
         busy_lvl_reg <= 1'h0;
      end else begin
         if (scl_q[2] == scl_q[1]) begin
            scl_lvl_reg <= scl_q[2];
         end
         if (sda_q[2] == sda_q[1]) begin
            sda_lvl_reg <= sda_q[2];
         end
         if (busy_q[2] == busy_q[1]) begin
            busy_lvl_reg <= busy_q[2];
         end
         scl_old_reg <= scl_lvl_reg;
         sda_old_reg <= sda_lvl_reg;
      end
   end

   // bus events
   assign scl_rise  = scl_lvl_reg & ~scl_old_reg;
   assign scl_fall  = ~scl_lvl_reg & scl_old_reg;
   assign start_det = scl_lvl_reg & scl_old_reg & sda_old_reg & ~sda_lvl_reg;
   assign stop_det  = scl_lvl_reg & scl_old_reg & ~sda_old_reg & sda_lvl_reg;
   assign rx_byte   = {shift_reg[6:0], sda_lvl_reg};

   // capture fetched byte when the answer toggle arrives
   always_ff @(posedge I_LINK_CLK) begin
      if (!link_rst_n) begin
         ack_seen_reg  <= 1'h0;
         link_data_reg <= `MEM_RESET;
      end else if (ack_q[2] == ack_q[1] && ack_q[2] != ack_seen_reg) begin
         ack_seen_reg  <= ack_q[2];
         link_data_reg <= rdata_reg;
      end
   end

   // serial protocol engine
   always_ff @(posedge I_LINK_CLK) begin
      if (!link_rst_n) begin
         state_reg    <= eeprom_read_pkg::ST_IDLE;
         kind_reg     <= eeprom_read_pkg::K_SEL;
         bit_reg      <= 4'h0;
         shift_reg    <= 8'h00;
         addr_hi_reg  <= 8'h00;
         cnt_reg      <= '0;
         reg_sel_reg  <= 1'h0;
         oe_reg       <= 1'h0;
         rd_reg       <= 1'h0;
         mack_reg     <= 1'h0;
         tx_reg       <= 8'h00;
         req_tog_reg  <= 1'h0;
         req_addr_reg <= '0;
         req_sel_reg  <= 1'h0;
      end else if (start_det) begin
         state_reg <= eeprom_read_pkg::ST_RX; // repeated start too [RL4]
         kind_reg  <= eeprom_read_pkg::K_SEL;
         bit_reg   <= 4'h0;
         oe_reg    <= 1'h0;
      end else if (stop_det) begin
         state_reg <= eeprom_read_pkg::ST_IDLE; // counter untouched [RL20]
         oe_reg    <= 1'h0;
      end else begin
         unique case (state_reg)
            eeprom_read_pkg::ST_IDLE: begin
               oe_reg <= 1'h0; // released until next start [RL19]
            end
            // byte reception, msb first
            eeprom_read_pkg::ST_RX: begin
               if (scl_rise) begin
                  shift_reg <= rx_byte;
                  bit_reg   <= bit_reg + 4'h1;
                  if (bit_reg == `LAST_BIT) begin
                     unique case (kind_reg)
                        eeprom_read_pkg::K_SEL: begin
                           // busy device stays deaf [RL18] [RL13]
                           if (rx_byte[7:1] == SELECT_CODE && !busy_lvl_reg) begin
                              state_reg <= eeprom_read_pkg::ST_RX_ACK; // [RL15]
                              rd_reg    <= (rx_byte[0] == `DIR_READ);
                              if (rx_byte[0] == `DIR_READ) begin
                                 req_tog_reg  <= ~req_tog_reg; // [RL6]
                                 req_addr_reg <= cnt_reg;
                                 req_sel_reg  <= reg_sel_reg;
                              end
                           end else begin
                              state_reg <= eeprom_read_pkg::ST_IDLE;
                           end
                        end
                        eeprom_read_pkg::K_HI: begin
                           addr_hi_reg <= rx_byte;
                           rd_reg      <= 1'h0;
                           state_reg   <= eeprom_read_pkg::ST_RX_ACK;
                        end
                        default: begin
                           // load counter from both address bytes [RL16]
                           cnt_reg     <= ADDR_W'({addr_hi_reg, rx_byte});
                           reg_sel_reg <= addr_hi_reg[`REG_SEL_BIT]; // [RL10]
                           rd_reg      <= 1'h0;
                           state_reg   <= eeprom_read_pkg::ST_RX_ACK;
                        end
                     endcase
                  end
               end
            end
            // ninth slot acknowledge, then data or next byte
            eeprom_read_pkg::ST_RX_ACK: begin
               if (scl_fall) begin
                  if (!oe_reg) begin
                     oe_reg <= 1'h1; // [RL15] [RL16]
                  end else begin
                     bit_reg <= 4'h0;
                     if (rd_reg) begin
                        tx_reg    <= link_data_reg; // [RL4] [RL6]
                        oe_reg    <= ~link_data_reg[7];
                        state_reg <= eeprom_read_pkg::ST_TX;
                     end else begin
                        oe_reg <= 1'h0;
                        unique case (kind_reg)
                           eeprom_read_pkg::K_SEL: begin
                              kind_reg  <= eeprom_read_pkg::K_HI;
                              state_reg <= eeprom_read_pkg::ST_RX;
                           end
                           eeprom_read_pkg::K_HI: begin
                              kind_reg  <= eeprom_read_pkg::K_LO;
                              state_reg <= eeprom_read_pkg::ST_RX;
                           end
                           default: begin
                              state_reg <= eeprom_read_pkg::ST_IDLE;
                           end
                        endcase
                     end
                  end
               end
            end
            // shift data out on each falling edge
            eeprom_read_pkg::ST_TX: begin
               if (scl_fall) begin
                  if (bit_reg == `LAST_BIT) begin
                     oe_reg    <= 1'h0; // release for master ack [RL3]
                     mack_reg  <= 1'h0;
                     state_reg <= eeprom_read_pkg::ST_TX_ACK;
                  end else begin
                     bit_reg <= bit_reg + 4'h1;
                     tx_reg  <= {tx_reg[6:0], 1'h0};
                     oe_reg  <= ~tx_reg[6];
                  end
               end
            end
            // sample master ack in the ninth slot
            eeprom_read_pkg::ST_TX_ACK: begin
               if (scl_rise) begin
                  if (!reg_sel_reg) begin
                     cnt_reg <= cnt_reg + 1'h1; // natural wrap [RL2] [RL9]
                  end
                  if (sda_lvl_reg) begin
                     state_reg <= eeprom_read_pkg::ST_IDLE; // [RL3]
                  end else begin
                     mack_reg     <= 1'h1;
                     req_tog_reg  <= ~req_tog_reg; // next byte [RL7]
                     req_sel_reg  <= reg_sel_reg; // same register [RL12]
                     req_addr_reg <= reg_sel_reg ? cnt_reg : cnt_reg + 1'h1;
                  end
               end else if (scl_fall && mack_reg) begin
                  bit_reg   <= 4'h0;
                  tx_reg    <= link_data_reg; // [RL7]
                  oe_reg    <= ~link_data_reg[7];
                  state_reg <= eeprom_read_pkg::ST_TX;
               end
            end
            default: begin
               state_reg <= eeprom_read_pkg::ST_IDLE;
               oe_reg    <= 1'h0;
            end
         endcase
      end
   end

   // open-drain data pin
   assign O_SDA_O  = 1'h0;
   assign O_SDA_OE = oe_reg;

   // fetch request synchroniser in the core domain
   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
         req_q <= 3'h0;
      end else begin
         req_q <= {req_q[1:0], req_tog_reg};
      end
   end
   assign req_new = (req_q[2] == req_q[1]) && (req_q[2] != req_seen_reg);

   // serve fetch; protection never gates data [RL1]
   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
         req_seen_reg <= 1'h0;
         ack_tog_reg  <= 1'h0;
         rdata_reg    <= `MEM_RESET;
      end else if (req_new) begin
         req_seen_reg <= req_q[2];
         ack_tog_reg  <= ~ack_tog_reg;
         if (req_sel_reg) begin
            rdata_reg <= {4'h0, prot_reg[3:0]}; // [RL10] [RL11]
         end else begin
            rdata_reg <= mem_reg[req_addr_reg];
         end
      end
   end

   // protection register, frozen once locked
   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
         prot_reg <= `PROT_RESET; // [RL14]
      end else if (I_PROT_WR && !prot_reg[`PROT_LOCK_BIT]) begin
         prot_reg <= {4'h0, I_PROT_WDATA[3:0]};
      end
   end

   // field decode for the write side [RL17]
   assign O_PROT_ACTIVE = prot_reg[`PROT_ACT_BIT];
   assign O_PROT_SIZE   = prot_reg[`PROT_SIZE_HI:`PROT_SIZE_LO];
   assign O_PROT_LOCK   = prot_reg[`PROT_LOCK_BIT];

   // array storage, one flop byte per entry
   for (genvar i = 0; i < DEPTH; i++) begin : g_mem
      always_ff @(posedge I_CLK) begin
         if (!I_RESETN) begin
            mem_reg[i] <= `MEM_RESET; // [RL14]
         end else if (I_MEM_WR && I_MEM_WADDR == ADDR_W'(i)) begin
            mem_reg[i] <= I_MEM_WDATA;
         end
      end
   end

   // checks on the link side
   default clocking cb @(posedge I_LINK_CLK);
   endclocking
   default disable iff (!link_rst_n);

   sequence s_ack_sample;
      state_reg == eeprom_read_pkg::ST_TX_ACK && scl_rise;
   endsequence

   sequence s_last_addr_bit;
      state_reg == eeprom_read_pkg::ST_RX && bit_reg == `LAST_BIT && scl_rise;
   endsequence

   AST_NACK_IDLE: assert property ( // [RL3]
      s_ack_sample ##0 sda_lvl_reg |=> state_reg == eeprom_read_pkg::ST_IDLE && !oe_reg)
      else $error("nack did not end the read");
   AST_INC_ONE: assert property ( // [RL2]
      s_ack_sample ##0 !reg_sel_reg |=> cnt_reg == ADDR_W'($past(cnt_reg) + 1'h1))
      else $error("counter did not advance by one");
   AST_WRAP: assert property ( // [RL9]
      s_ack_sample ##0 (!reg_sel_reg && &cnt_reg) |=> cnt_reg == '0)
      else $error("counter did not wrap to zero");
   AST_REG_REPEAT: assert property ( // [RL12]
      s_ack_sample ##0 (reg_sel_reg && !sda_lvl_reg) |=> $stable(cnt_reg) && req_sel_reg)
      else $error("register read moved on");
   AST_BUSY_DEAF: assert property ( // [RL18]
      s_last_addr_bit ##0 (kind_reg == eeprom_read_pkg::K_SEL && busy_lvl_reg)
      |=> state_reg == eeprom_read_pkg::ST_IDLE ##1 !oe_reg)
      else $error("select served while busy");
   AST_IDLE_RELEASED: assert property ( // [RL19]
      state_reg == eeprom_read_pkg::ST_IDLE |-> !oe_reg)
      else $error("data line driven while idle");
   AST_STOP_KEEPS: assert property ( // [RL20]
      stop_det |=> $stable(cnt_reg))
      else $error("stop changed the counter");
   AST_ADDR_LOAD: assert property ( // [RL16]
      s_last_addr_bit ##0 kind_reg == eeprom_read_pkg::K_LO
      |=> reg_sel_reg == $past(addr_hi_reg[7]) && state_reg == eeprom_read_pkg::ST_RX_ACK)
      else $error("address bytes not loaded");
   AST_FIRST_BIT: assert property ( // [RL6]
      state_reg == eeprom_read_pkg::ST_RX_ACK && rd_reg && oe_reg && scl_fall
      |=> state_reg == eeprom_read_pkg::ST_TX && oe_reg == !$past(link_data_reg[7]))
      else $error("first data bit wrong");

   // check on the core side
   AST_REG_DATA: assert property ( // [RL11]
      @(posedge I_CLK) disable iff (!I_RESETN)
      req_new && req_sel_reg |=> rdata_reg == {4'h0, $past(prot_reg[3:0])})
      else $error("register byte upper bits not zero");

endmodule
`default_nettype wire

// file: testbench/serial_bus_master.sv
`timescale 1ns/1ps
`default_nettype none
module serial_bus_master (
   input  wire logic i_clk,
   output logic      o_scl,
   output logic      o_sda,
   input  wire logic i_sda
);
   // bus released, clock stands high between frames
   initial begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge i_clk);
   endtask

   // start or repeated start: data falls while clock high
   task automatic start_cond();
      wait_clk(20);
      o_sda <= 1'b1;
      wait_clk(100);
      o_scl <= 1'b1;
      wait_clk(70);
      o_sda <= 1'b0;
      wait_clk(70);
      o_scl <= 1'b0;
   endtask

   // one bit: data set in the low phase, line sampled at end of high
   task automatic xfer_bit(input logic b, output logic seen);
      wait_clk(20);
      o_sda <= b;
      wait_clk(110);
      o_scl <= 1'b1;
      wait_clk(70);
      seen = i_sda;
      o_scl <= 1'b0;
   endtask

   // byte out msb first, then release for the acknowledge slot
   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         xfer_bit(b[i], s);
      end
      xfer_bit(1'b1, s);
      ack = ~s;
   endtask

   // byte in, then acknowledge to continue or withhold to end
   task automatic get_byte(output logic [7:0] d, input logic more);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         xfer_bit(1'b1, s);
         d[i] = s;
      end
      xfer_bit(~more, s);
   endtask

   // stop: data rises while clock high, then bus free time
   task automatic stop_cond();
      wait_clk(20);
      o_sda <= 1'b0;
      wait_clk(110);
      o_scl <= 1'b1;
      wait_clk(70);
      o_sda <= 1'b1;
      wait_clk(130);
   endtask
endmodule
`default_nettype wire

// file: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam logic [6:0] CODE = 7'h33; // arbitrary value
   logic        i_clk;
   logic        i_resetn;
   logic        i_link_clk;
   logic        i_prog_busy;
   logic        i_mem_wr;
   logic        i_prot_wr;
   logic [11:0] i_mem_waddr;
   logic [7:0]  i_mem_wdata;
   logic [7:0]  i_prot_wdata;
   logic [7:0]  rd;
   logic        scl;
   logic        sda_drv;
   logic        sda_o;
   logic        sda_oe;
   logic        sda_line;
   logic        ack;
   logic        prot_active;
   logic        prot_lock;
   logic [1:0]  prot_size;
   int          miscompares;
   int          n_checks;

   eeprom_serial_read_engine #(.ADDR_W(12), .SELECT_CODE(CODE)) dut (
      .I_CLK(i_clk), .I_RESETN(i_resetn), .I_LINK_CLK(i_link_clk),
      .I_SCL(scl), .I_SDA_I(sda_line), .O_SDA_O(sda_o), .O_SDA_OE(sda_oe),
      .I_PROG_BUSY(i_prog_busy), .I_MEM_WR(i_mem_wr), .I_MEM_WADDR(i_mem_waddr),
      .I_MEM_WDATA(i_mem_wdata), .I_PROT_WR(i_prot_wr), .I_PROT_WDATA(i_prot_wdata),
      .O_PROT_ACTIVE(prot_active), .O_PROT_SIZE(prot_size), .O_PROT_LOCK(prot_lock)
   );

   serial_bus_master u_master (.i_clk(i_clk), .o_scl(scl), .o_sda(sda_drv), .i_sda(sda_line));

   // wired-and data line with pull-up
   assign sda_line = (sda_oe ? sda_o : 1'b1) & sda_drv;

   // core and unrelated link clocks
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   initial begin
      i_link_clk = 1'b0;
      #13;
      forever #40 i_link_clk = ~i_link_clk;
   end

   task automatic give_verdict();
      if (miscompares == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h, wanted %h", $time, seen, exp);
      end
   endtask

   task automatic mem_wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_mem_waddr <= a;
      i_mem_wdata <= d;
      i_mem_wr    <= 1'b1;
      @(posedge i_clk);
      i_mem_wr    <= 1'b0;
   endtask

   task automatic prot_wr(input logic [7:0] d);
      @(posedge i_clk);
      i_prot_wdata <= d;
      i_prot_wr    <= 1'b1;
      @(posedge i_clk);
      i_prot_wr    <= 1'b0;
      repeat (2) @(posedge i_clk);
      #1;
   endtask

   // start plus select byte, acknowledge compared
   task automatic sel(input logic [6:0] code, input logic rw, input logic exp_ack);
      u_master.start_cond();
      u_master.put_byte({code, rw}, ack);
      check({7'h00, ack}, {7'h00, exp_ack});
   endtask

   // dummy write of both address bytes, then repeated start for read
   task automatic addr(input logic [15:0] a);
      sel(CODE, 1'b0, 1'b1);
      u_master.put_byte(a[15:8], ack);
      check({7'h00, ack}, 8'h01);
      u_master.put_byte(a[7:0], ack);
      check({7'h00, ack}, 8'h01);
      sel(CODE, 1'b1, 1'b1);
   endtask

   task automatic get(input logic [7:0] exp, input logic more);
      u_master.get_byte(rd, more);
      check(rd, exp);
   endtask

   // hang guard, tests take about 800 us
   initial begin
      #1_000_000;
      miscompares++;
      give_verdict();
   end

   initial begin
      miscompares  = 0;
      n_checks     = 0;
      i_resetn     = 1'b0;
      i_prog_busy  = 1'b0;
      i_mem_wr     = 1'b0;
      i_mem_waddr  = 12'h000;
      i_mem_wdata  = 8'h00;
      i_prot_wr    = 1'b0;
      i_prot_wdata = 8'h00;
      // link side stretches reset through its own synchroniser
      repeat (10) @(posedge i_clk);
      i_resetn <= 1'b1;
      repeat (50) @(posedge i_clk);
      #1;
      check({4'h0, prot_active, prot_size, prot_lock}, 8'h00);
      // current read at counter zero returns erased content
      sel(CODE, 1'b1, 1'b1);
      get(8'hFF, 1'b0);
      u_master.stop_cond();
      mem_wr(12'h010, 8'hA5);
      mem_wr(12'h011, 8'h3C);
      mem_wr(12'h012, 8'h77);
      mem_wr(12'hFFF, 8'h5A);
      mem_wr(12'h000, 8'hC3);
      mem_wr(12'h020, 8'h91); // msb set, line free for the abort stop
      mem_wr(12'h021, 8'h22);
      // random read with a sequential byte, then current read
      addr(16'h0010);
      get(8'hA5, 1'b1);
      get(8'h3C, 1'b0);
      u_master.stop_cond();
      sel(CODE, 1'b1, 1'b1);
      get(8'h77, 1'b0);
      u_master.stop_cond();
      // roll-over, then clocks after a nack find the line released
      addr(16'h0FFF);
      get(8'h5A, 1'b1);
      get(8'hC3, 1'b0);
      get(8'hFF, 1'b0);
      u_master.stop_cond();
      // abort right after the read select keeps the counter
      addr(16'h0020);
      u_master.stop_cond();
      sel(CODE, 1'b1, 1'b1);
      get(8'h91, 1'b0);
      u_master.stop_cond();
      // foreign code and busy device get no acknowledge
      sel(CODE ^ 7'h01, 1'b1, 1'b0);
      u_master.stop_cond();
      i_prog_busy <= 1'b1;
      sel(CODE, 1'b1, 1'b0);
      u_master.stop_cond();
      sel(CODE, 1'b0, 1'b0);
      u_master.stop_cond();
      i_prog_busy <= 1'b0;
      sel(CODE, 1'b1, 1'b1);
      get(8'h22, 1'b0);
      u_master.stop_cond();
      // upper half protected and locked, second write ignored
      prot_wr(8'hFB);
      check({4'h0, prot_active, prot_size, prot_lock}, 8'h0B);
      prot_wr(8'h00);
      check({4'h0, prot_active, prot_size, prot_lock}, 8'h0B);
      addr(16'h8000);
      get(8'h0B, 1'b1);
      get(8'h0B, 1'b1);
      get(8'h0B, 1'b0);
      u_master.stop_cond();
      // protected area still reads normally
      addr(16'h0FFF);
      get(8'h5A, 1'b0);
      u_master.stop_cond();
      give_verdict();
   end
endmodule
`default_nettype wire
